// File: core/uaf_top.sv
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module uaf_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_in,
  output logic tx_out,
  input wire logic cts_n_in,
  output logic rts_n_out,
  output logic irq_out
);
  // Last tick index of a bit for the sampling mode
  function automatic logic [4:0] bit_last(input logic [1:0] m);
    bit_last = (m == 2'b01) ? 5'h07 : (m == 2'b10) ? 5'h03 : 5'h0f;
  endfunction
  // Level for a two-bit trigger code
  function automatic logic [5:0] trig_lvl(input logic [1:0] c);
    trig_lvl = (c == 2'b00) ? 6'h08 : (c == 2'b01) ? 6'h10 : (c == 2'b10) ? 6'h18 : 6'h1c;
  endfunction
  // Parity of the active data bits
  function automatic logic par_of(input logic [7:0] d, input logic [1:0] wl, input logic even);
    logic [7:0] m;
    m = 8'hff >> (3'h3 - {1'b0, wl});
    par_of = (^(d & m)) ^ ~even;
  endfunction

  // Software visible registers
  logic [7:0] ier_r, ier_nxt;
  logic [7:0] fcr_r, fcr_nxt;
  logic [7:0] lcr_r, lcr_nxt;
  logic [7:0] mcr_r, mcr_nxt;
  logic [7:0] efr_r, efr_nxt;
  logic [7:0] dld_r, dld_nxt;
  logic [15:0] div_r, div_nxt;
  // Bus answer
  logic [31:0] rdata_r, rdata_nxt;
  logic wait_r, wait_nxt;
  // Sticky flags and outputs
  logic flow_r, flow_nxt;
  logic ovr_r, ovr_nxt;
  logic rts_n_r, rts_n_nxt;
  logic cts_prev_r, cts_prev_nxt;
  logic irq_r, irq_nxt;
  // Oversampling tick divider
  logic [15:0] tdiv_r, tdiv_nxt;
  logic tick_r, tick_nxt;
  // Timeout counter in ticks
  logic [10:0] tout_r, tout_nxt;
  // FIFOs
  localparam int DEPTH_C = uaf_pkg::DEPTH;
  logic [7:0] txm_r [DEPTH_C];
  logic [7:0] txm_nxt [DEPTH_C];
  uaf_pkg::uaf_rx_entry_s rxm_r [DEPTH_C];
  uaf_pkg::uaf_rx_entry_s rxm_nxt [DEPTH_C];
  logic [uaf_pkg::PTR_W-1:0] txw_r, txw_nxt, txr_r, txr_nxt, rxw_r, rxw_nxt, rxr_r, rxr_nxt;
  logic [uaf_pkg::CNT_W-1:0] txc_r, txc_nxt, rxc_r, rxc_nxt;
  // Strobes from the serial engines
  logic tx_pop;
  logic rx_push;
  uaf_pkg::uaf_rx_entry_s rx_ent;
  logic tx_idle;

  // Decoded bus access
  logic acc, wr_acc, rd_acc;
  logic fifo_en;
  logic [5:0] cap;
  logic [1:0] mode;
  logic [4:0] blast;
  uaf_pkg::uaf_rx_entry_s head;
  logic [5:0] frame_bits;
  logic [10:0] tout_lim;
  logic [5:0] rts_hi, rts_lo;

  assign acc = (avs_read | avs_write) & ~wait_r;
  assign wr_acc = acc & avs_write;
  assign rd_acc = acc & avs_read;
  assign fifo_en = fcr_r[uaf_pkg::FC_ENABLE];
  assign cap = fifo_en ? 6'h20 : 6'h01;
  assign mode = dld_r[5:4];
  assign blast = bit_last(mode);
  assign head = rxm_r[rxr_r];
  assign frame_bits = 6'h07 + {4'h0, lcr_r[1:0]} + {5'h00, lcr_r[uaf_pkg::LC_PAR_EN]}
                      + {5'h00, lcr_r[uaf_pkg::LC_STOP2]};
  assign tout_lim = 11'((({5'h00, frame_bits} << 2) + 11'h00c) * ({6'h00, blast} + 11'h001));
  assign rts_hi = (fcr_r[7:6] == 2'b00) ? 6'h10 : (fcr_r[7:6] == 2'b01) ? 6'h18 : 6'h1c;
  assign rts_lo = (fcr_r[7:6] == 2'b00) ? 6'h00 : (fcr_r[7:6] == 2'b01) ? 6'h08
                : (fcr_r[7:6] == 2'b10) ? 6'h10 : 6'h18;

  // Register file, bus slave, FIFOs, flags and flow control
  always_comb begin
    logic [7:0] line_status, interrupt_source;
    logic rts_up, cts_up, rx_int, tx_int, to_int;
    line_status = 8'h00;
    interrupt_source = 8'h00;
    rts_up = 1'b0;
    cts_up = 1'b0;
    rx_int = 1'b0;
    tx_int = 1'b0;
    to_int = 1'b0;
    ier_nxt = ier_r;
    fcr_nxt = fcr_r;
    lcr_nxt = lcr_r;
    mcr_nxt = mcr_r;
    efr_nxt = efr_r;
    dld_nxt = dld_r;
    div_nxt = div_r;
    flow_nxt = flow_r;
    ovr_nxt = ovr_r;
    txm_nxt = txm_r;
    rxm_nxt = rxm_r;
    txw_nxt = txw_r;
    txr_nxt = txr_r;
    rxw_nxt = rxw_r;
    rxr_nxt = rxr_r;
    txc_nxt = txc_r;
    rxc_nxt = rxc_r;
    // Tick divider, one pulse every div_r clocks
    if (tdiv_r + 16'h0001 >= div_r) begin
      tdiv_nxt = 16'h0000;
      tick_nxt = 1'b1;
    end else begin
      tdiv_nxt = tdiv_r + 16'h0001;
      tick_nxt = 1'b0;
    end
    // Interrupt conditions
    rx_int = ier_r[uaf_pkg::IE_RX] & (fifo_en ? (rxc_r >= trig_lvl(fcr_r[7:6])) : (rxc_r != 6'h00));
    if (fifo_en) begin
      tx_int = ier_r[uaf_pkg::IE_TX] & (txc_r < trig_lvl(fcr_r[5:4]));
    end else begin
      tx_int = ier_r[uaf_pkg::IE_TX] & (txc_r == 6'h00);
    end
    to_int = ier_r[uaf_pkg::IE_RX] & (tout_r >= tout_lim) & (rxc_r != 6'h00);
    // Status views
    line_status[0] = rxc_r != 6'h00;
    line_status[1] = ovr_r;
    line_status[2] = (rxc_r != 6'h00) & head.pe;
    line_status[3] = (rxc_r != 6'h00) & head.fe;
    line_status[4] = (rxc_r != 6'h00) & head.brk;
    line_status[5] = txc_r == 6'h00;
    line_status[6] = (txc_r == 6'h00) & tx_idle;
    interrupt_source[uaf_pkg::IS_RX] = rx_int;
    interrupt_source[uaf_pkg::IS_TX] = tx_int;
    interrupt_source[uaf_pkg::IS_TIMEOUT] = to_int;
    interrupt_source[uaf_pkg::IS_FLOW] = flow_r;
    irq_nxt = rx_int | tx_int | to_int | flow_r;
    // Timeout counter restarts on new character or holding-register read
    if (rx_push || (rd_acc && avs_address == uaf_pkg::REG_HOLDING) || rxc_r == 6'h00) begin
      tout_nxt = 11'h000;
    end else if (tick_r && tout_r < tout_lim) begin
      tout_nxt = tout_r + 11'h001;
    end else begin
      tout_nxt = tout_r;
    end
    // Bus answer one cycle after a request is seen
    wait_nxt = ~((avs_read | avs_write) & wait_r);
    rdata_nxt = rdata_r;
    // Only reads load the answer, so read data hold across writes
    if (avs_read && wait_r) begin
      if (avs_address == uaf_pkg::REG_HOLDING) begin
        rdata_nxt = {24'h000000, head.data};
      end else if (avs_address == uaf_pkg::REG_INT_ENABLE) begin
        rdata_nxt = {24'h000000, ier_r};
      end else if (avs_address == uaf_pkg::REG_INT_SOURCE) begin
        rdata_nxt = {24'h000000, interrupt_source};
      end else if (avs_address == uaf_pkg::REG_LINE_CONTROL) begin
        rdata_nxt = {24'h000000, lcr_r};
      end else if (avs_address == uaf_pkg::REG_MODEM_CONTROL) begin
        rdata_nxt = {24'h000000, mcr_r};
      end else if (avs_address == uaf_pkg::REG_LINE_STATUS) begin
        rdata_nxt = {24'h000000, line_status[7:6], line_status[5], line_status[4:0] | 5'h00} | {24'h000000, |line_status[4:1], 7'h00};
      end else if (avs_address == uaf_pkg::REG_ENHANCED) begin
        rdata_nxt = {24'h000000, efr_r};
      end else if (avs_address == uaf_pkg::REG_SAMPLING) begin
        rdata_nxt = {24'h000000, dld_r};
      end else if (avs_address == uaf_pkg::REG_TICK_DIV) begin
        rdata_nxt = {16'h0000, div_r};
      end else begin
        rdata_nxt = 32'h00000000;
      end
    end
    // Transmit FIFO pop by the shifter
    if (tx_pop) begin
      txr_nxt = txr_r + 5'h01;
      txc_nxt = txc_nxt - 6'h01;
    end
    // Receive FIFO push, keeps filling until full even with request off
    if (rx_push) begin
      if (rxc_r < cap) begin
        rxm_nxt[rxw_r] = rx_ent;
        rxw_nxt = rxw_r + 5'h01;
        rxc_nxt = rxc_nxt + 6'h01;
      end else begin
        ovr_nxt = 1'b1;
      end
    end
    // Register writes and read side effects
    if (wr_acc) begin
      if (avs_address == uaf_pkg::REG_HOLDING) begin
        if (txc_r < cap) begin
          txm_nxt[txw_r] = avs_writedata[7:0];
          txw_nxt = txw_r + 5'h01;
          txc_nxt = txc_nxt + 6'h01;
        end
      end else if (avs_address == uaf_pkg::REG_INT_ENABLE) begin
        ier_nxt[5:0] = avs_writedata[5:0];
        if (efr_r[uaf_pkg::EF_UNLOCK]) begin
          ier_nxt[7:6] = avs_writedata[7:6];
        end
      end else if (avs_address == uaf_pkg::REG_INT_SOURCE) begin
        fcr_nxt = {avs_writedata[7:3], 2'b00, avs_writedata[0]};
        if (avs_writedata[uaf_pkg::FC_RX_RESET] || avs_writedata[0] != fcr_r[0]) begin
          rxw_nxt = 5'h00;
          rxr_nxt = 5'h00;
          rxc_nxt = 6'h00;
        end
        if (avs_writedata[uaf_pkg::FC_TX_RESET] || avs_writedata[0] != fcr_r[0]) begin
          txw_nxt = txr_nxt;
          txc_nxt = 6'h00;
        end
      end else if (avs_address == uaf_pkg::REG_LINE_CONTROL) begin
        lcr_nxt = avs_writedata[7:0];
      end else if (avs_address == uaf_pkg::REG_MODEM_CONTROL) begin
        mcr_nxt = avs_writedata[7:0];
      end else if (avs_address == uaf_pkg::REG_ENHANCED) begin
        efr_nxt = avs_writedata[7:0];
      end else if (avs_address == uaf_pkg::REG_SAMPLING) begin
        dld_nxt = avs_writedata[7:0];
      end else if (avs_address == uaf_pkg::REG_TICK_DIV) begin
        div_nxt = (avs_writedata[15:0] == 16'h0000) ? 16'h0001 : avs_writedata[15:0];
      end
    end
    if (rd_acc) begin
      if (avs_address == uaf_pkg::REG_HOLDING && rxc_r != 6'h00) begin
        rxr_nxt = rxr_r + 5'h01;
        rxc_nxt = rxc_nxt - 6'h01;
      end else if (avs_address == uaf_pkg::REG_INT_SOURCE) begin
        flow_nxt = 1'b0;
      end else if (avs_address == uaf_pkg::REG_LINE_STATUS) begin
        ovr_nxt = 1'b0;
      end
    end
    if (rx_push && rxc_r >= cap) begin
      ovr_nxt = 1'b1;
    end
    // Request-to-send pin, auto mode with hysteresis once both the request bit and the auto-request feature bit are on
    rts_n_nxt = rts_n_r;
    if (!mcr_r[uaf_pkg::MC_RTS]) begin
      rts_n_nxt = 1'b1;
    end else if (!efr_r[uaf_pkg::EF_AUTO_RTS]) begin
      rts_n_nxt = 1'b0;
    end else if (rxc_r >= rts_hi) begin
      rts_n_nxt = 1'b1;
    end else if (rxc_r <= rts_lo) begin
      rts_n_nxt = 1'b0;
    end
    // Flow-control interrupt events, set wins over a clearing read
    rts_up = ~rts_n_r & rts_n_nxt;
    cts_up = ~cts_prev_r & cts_n_in;
    cts_prev_nxt = cts_n_in;
    if (rts_up && ier_r[uaf_pkg::IE_RTS] && efr_r[uaf_pkg::EF_UNLOCK]) begin
      flow_nxt = 1'b1;
    end
    if (cts_up && ier_r[uaf_pkg::IE_CTS] && efr_r[uaf_pkg::EF_UNLOCK]) begin
      flow_nxt = 1'b1;
    end
  end

  // Register stage of the control group
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ier_r <= uaf_pkg::RST_BYTE;
      fcr_r <= uaf_pkg::RST_BYTE;
      lcr_r <= uaf_pkg::RST_LINE_CONTROL;
      mcr_r <= uaf_pkg::RST_BYTE;
      efr_r <= uaf_pkg::RST_BYTE;
      dld_r <= uaf_pkg::RST_BYTE;
      div_r <= uaf_pkg::RST_TICK_DIV;
      rdata_r <= 32'h00000000;
      wait_r <= 1'b1;
      flow_r <= 1'b0;
      ovr_r <= 1'b0;
      rts_n_r <= 1'b1;
      cts_prev_r <= 1'b0;
      irq_r <= 1'b0;
      tdiv_r <= 16'h0000;
      tick_r <= 1'b0;
      tout_r <= 11'h000;
      txw_r <= 5'h00;
      txr_r <= 5'h00;
      rxw_r <= 5'h00;
      rxr_r <= 5'h00;
      txc_r <= 6'h00;
      rxc_r <= 6'h00;
    end else begin
      ier_r <= ier_nxt;
      fcr_r <= fcr_nxt;
      lcr_r <= lcr_nxt;
      mcr_r <= mcr_nxt;
      efr_r <= efr_nxt;
      dld_r <= dld_nxt;
      div_r <= div_nxt;
      rdata_r <= rdata_nxt;
      wait_r <= wait_nxt;
      flow_r <= flow_nxt;
      ovr_r <= ovr_nxt;
      rts_n_r <= rts_n_nxt;
      cts_prev_r <= cts_prev_nxt;
      irq_r <= irq_nxt;
      tdiv_r <= tdiv_nxt;
      tick_r <= tick_nxt;
      tout_r <= tout_nxt;
      txw_r <= txw_nxt;
      txr_r <= txr_nxt;
      rxw_r <= rxw_nxt;
      rxr_r <= rxr_nxt;
      txc_r <= txc_nxt;
      rxc_r <= rxc_nxt;
    end
  end

  // FIFO storage needs no reset
  always_ff @(posedge core_clk) begin
    txm_r <= txm_nxt;
    rxm_r <= rxm_nxt;
  end

  // Transmit shifter state
  uaf_pkg::uaf_ser_e txs_r, txs_nxt;
  logic [4:0] txt_r, txt_nxt;
  logic [2:0] txb_r, txb_nxt;
  logic [7:0] tsh_r, tsh_nxt;
  logic tpar_r, tpar_nxt;
  logic txo_r, txo_nxt;
  assign tx_idle = txs_r == uaf_pkg::SER_IDLE;

  // Transmit shifter next state
  always_comb begin
    logic bit_end;
    bit_end = tick_r && txt_r == blast;
    txs_nxt = txs_r;
    txt_nxt = txt_r;
    txb_nxt = txb_r;
    tsh_nxt = tsh_r;
    tpar_nxt = tpar_r;
    txo_nxt = txo_r;
    tx_pop = 1'b0;
    if (txs_r != uaf_pkg::SER_IDLE && tick_r) begin
      txt_nxt = bit_end ? 5'h00 : txt_r + 5'h01;
    end
    case (txs_r)
      uaf_pkg::SER_IDLE: begin
        // Clear-to-send high holds the next character back
        if (tick_r && txc_r != 6'h00 && !(efr_r[uaf_pkg::EF_AUTO_CTS] && cts_n_in)) begin
          tx_pop = 1'b1;
          tsh_nxt = txm_r[txr_r];
          tpar_nxt = par_of(txm_r[txr_r], lcr_r[1:0], lcr_r[uaf_pkg::LC_PAR_EVEN]);
          txo_nxt = 1'b0;
          txt_nxt = 5'h00;
          txb_nxt = 3'h0;
          txs_nxt = uaf_pkg::SER_START;
        end
      end
      uaf_pkg::SER_START: begin
        if (bit_end) begin
          txo_nxt = tsh_r[0];
          txs_nxt = uaf_pkg::SER_DATA;
        end
      end
      uaf_pkg::SER_DATA: begin
        if (bit_end) begin
          if (txb_r == {1'b1, lcr_r[1:0]}) begin
            txb_nxt = 3'h0;
            txo_nxt = lcr_r[uaf_pkg::LC_PAR_EN] ? tpar_r : 1'b1;
            txs_nxt = lcr_r[uaf_pkg::LC_PAR_EN] ? uaf_pkg::SER_PAR : uaf_pkg::SER_STOP;
          end else begin
            txb_nxt = txb_r + 3'h1;
            tsh_nxt = tsh_r >> 1;
            txo_nxt = tsh_r[1];
          end
        end
      end
      uaf_pkg::SER_PAR: begin
        if (bit_end) begin
          txo_nxt = 1'b1;
          txs_nxt = uaf_pkg::SER_STOP;
        end
      end
      uaf_pkg::SER_STOP: begin
        if (bit_end) begin
          if (lcr_r[uaf_pkg::LC_STOP2] && txb_r == 3'h0) begin
            txb_nxt = 3'h1;
          end else begin
            txs_nxt = uaf_pkg::SER_IDLE;
          end
        end
      end
      default: begin
        txs_nxt = uaf_pkg::SER_IDLE;
        txo_nxt = 1'b1;
      end
    endcase
  end

  // Transmit shifter registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      txs_r <= uaf_pkg::SER_IDLE;
      txt_r <= 5'h00;
      txb_r <= 3'h0;
      tsh_r <= 8'h00;
      tpar_r <= 1'b0;
      txo_r <= 1'b1;
    end else begin
      txs_r <= txs_nxt;
      txt_r <= txt_nxt;
      txb_r <= txb_nxt;
      tsh_r <= tsh_nxt;
      tpar_r <= tpar_nxt;
      txo_r <= txo_nxt;
    end
  end

  // Receive shifter state
  uaf_pkg::uaf_ser_e rxs_r, rxs_nxt;
  logic [4:0] rxt_r, rxt_nxt;
  logic [2:0] rxb_r, rxb_nxt;
  logic [7:0] rsh_r, rsh_nxt;
  logic rpe_r, rpe_nxt;
  logic rprev_r, rprev_nxt;

  // Receive shifter next state
  always_comb begin
    logic mid;
    mid = tick_r && rxt_r == blast;
    rxs_nxt = rxs_r;
    rxt_nxt = rxt_r;
    rxb_nxt = rxb_r;
    rsh_nxt = rsh_r;
    rpe_nxt = rpe_r;
    rprev_nxt = tick_r ? rx_in : rprev_r;
    rx_push = 1'b0;
    rx_ent = '{brk: 1'b0, fe: 1'b0, pe: 1'b0, data: rsh_r >> (3'h3 - {1'b0, lcr_r[1:0]})};
    if (rxs_r != uaf_pkg::SER_IDLE && tick_r) begin
      rxt_nxt = mid ? 5'h00 : rxt_r + 5'h01;
    end
    case (rxs_r)
      uaf_pkg::SER_IDLE: begin
        if (tick_r && rprev_r && !rx_in) begin
          rxt_nxt = 5'h00;
          rxs_nxt = uaf_pkg::SER_START;
        end
      end
      uaf_pkg::SER_START: begin
        if (tick_r && rxt_r == (blast >> 1)) begin
          rxt_nxt = 5'h00;
          rxb_nxt = 3'h0;
          rpe_nxt = 1'b0;
          rxs_nxt = rx_in ? uaf_pkg::SER_IDLE : uaf_pkg::SER_DATA;
        end
      end
      uaf_pkg::SER_DATA: begin
        if (mid) begin
          rsh_nxt = {rx_in, rsh_r[7:1]};
          if (rxb_r == {1'b1, lcr_r[1:0]}) begin
            rxs_nxt = lcr_r[uaf_pkg::LC_PAR_EN] ? uaf_pkg::SER_PAR : uaf_pkg::SER_STOP;
          end else begin
            rxb_nxt = rxb_r + 3'h1;
          end
        end
      end
      uaf_pkg::SER_PAR: begin
        if (mid) begin
          rpe_nxt = rx_in != par_of(rx_ent.data, lcr_r[1:0], lcr_r[uaf_pkg::LC_PAR_EVEN]);
          rxs_nxt = uaf_pkg::SER_STOP;
        end
      end
      uaf_pkg::SER_STOP: begin
        if (mid) begin
          rx_push = 1'b1;
          rx_ent.pe = rpe_r;
          rx_ent.fe = ~rx_in;
          rx_ent.brk = ~rx_in && rx_ent.data == 8'h00;
          rxs_nxt = uaf_pkg::SER_IDLE;
        end
      end
      default: begin
        rxs_nxt = uaf_pkg::SER_IDLE;
      end
    endcase
  end

  // Receive shifter registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rxs_r <= uaf_pkg::SER_IDLE;
      rxt_r <= 5'h00;
      rxb_r <= 3'h0;
      rsh_r <= 8'h00;
      rpe_r <= 1'b0;
      rprev_r <= 1'b1;
    end else begin
      rxs_r <= rxs_nxt;
      rxt_r <= rxt_nxt;
      rxb_r <= rxb_nxt;
      rsh_r <= rsh_nxt;
      rpe_r <= rpe_nxt;
      rprev_r <= rprev_nxt;
    end
  end

  // Outputs straight from flops
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign tx_out = txo_r;
  assign rts_n_out = rts_n_r;
  assign irq_out = irq_r;
endmodule

// File: core/uaf_pkg.sv
// How it works
// - Each tx bit lasts 16, 8 or 4 ticks
// - Frame: start, data LSB first, parity, stop
// - FIFO mode: holding write pushes 32-deep tx FIFO
// - Non-FIFO: holding-empty set on shifter load
// - Non-FIFO: holding-empty raises enabled tx interrupt
// - FIFO mode: holding-empty while tx FIFO empty
// - FIFO mode: tx interrupt below tx trigger
// - Fully-empty needs shifter and FIFO empty
// - Start bit checked half a bit after fall
// - Later bits sampled at bit middle
// - Rx FIFO 32 entries of data plus tags
// - Holding read pops, tags follow new head
// - Holding register shows oldest rx character
// - Rx interrupt per character or at trigger
// - Timeout after four words plus twelve bits
// - Auto request needs feature bit and request bit
// - Flow interrupt on request output rising
// - Request deasserts at upper fill level
// - Request reasserts at lower fill level
// - Receiver keeps filling until FIFO full
// - Clear-to-send high stops after current stop
// - Flow interrupt when clear-to-send goes high
// - Mode field selects 16X, 8X or 4X
// - Word length field picks 5 to 8 bits
package uaf_pkg;
  // Word indices of the register map, byte address is four times the index
  localparam logic [3:0] REG_HOLDING = 4'h0;
  localparam logic [3:0] REG_INT_ENABLE = 4'h1;
  localparam logic [3:0] REG_INT_SOURCE = 4'h2;
  localparam logic [3:0] REG_LINE_CONTROL = 4'h3;
  localparam logic [3:0] REG_MODEM_CONTROL = 4'h4;
  localparam logic [3:0] REG_LINE_STATUS = 4'h5;
  localparam logic [3:0] REG_ENHANCED = 4'h6;
  localparam logic [3:0] REG_SAMPLING = 4'h7;
  localparam logic [3:0] REG_TICK_DIV = 4'h8;
  // Field positions
  localparam int IE_RX = 0;
  localparam int IE_TX = 1;
  localparam int IE_RTS = 6;
  localparam int IE_CTS = 7;
  localparam int FC_ENABLE = 0;
  localparam int FC_RX_RESET = 1;
  localparam int FC_TX_RESET = 2;
  localparam int LC_STOP2 = 2;
  localparam int LC_PAR_EN = 3;
  localparam int LC_PAR_EVEN = 4;
  localparam int MC_RTS = 1;
  localparam int EF_UNLOCK = 4;
  localparam int EF_AUTO_RTS = 6;
  localparam int EF_AUTO_CTS = 7;
  localparam int IS_RX = 0;
  localparam int IS_TX = 1;
  localparam int IS_TIMEOUT = 2;
  localparam int IS_FLOW = 5;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_LINE_CONTROL = 8'h03;
  localparam logic [15:0] RST_TICK_DIV = 16'h0001;
  // FIFO geometry
  localparam int DEPTH = 32;
  localparam int PTR_W = 5;
  localparam int CNT_W = 6;
  // Receive FIFO entry: three error tags and the data byte
  typedef struct packed {
    logic brk;
    logic fe;
    logic pe;
    logic [7:0] data;
  } uaf_rx_entry_s;
  // Serial state machines, one-hot
  typedef enum logic [4:0] {
    SER_IDLE = 5'h01,
    SER_START = 5'h02,
    SER_DATA = 5'h04,
    SER_PAR = 5'h08,
    SER_STOP = 5'h10
  } uaf_ser_e;
endpackage

// File: dv/uaf_monitor.sv
`timescale 1ns/1ps
// Watches the bus handshake and the serial pins
module uaf_monitor (
  input logic core_clk,
  input logic rst_n,
  input logic [3:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  input logic [31:0] avs_readdata,
  input logic avs_waitrequest,
  input logic rx_in,
  input logic tx_out,
  input logic cts_n_in,
  input logic rts_n_out,
  input logic irq_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // One wait cycle, then a one-cycle answer
  a_ack_after_req: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("no answer");
  a_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer too long");
  a_ack_has_req: assert property (!avs_waitrequest |-> avs_read || avs_write)
    else $error("answer without request");
  a_idle_no_ack: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("answer while idle");
  // Read data move only after a read
  a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved");
  // Pins idle at the first edge out of reset
  a_reset_idle: assert property ($rose(rst_n) |-> tx_out && rts_n_out && !irq_out)
    else $error("pins not idle");
  // Serial levels last at least one 4X bit
  a_bit_min_len: assert property ($changed(tx_out) |=> $stable(tx_out) [*3])
    else $error("bit too short");
  a_start_len: assert property ($fell(tx_out) |-> !tx_out [*4])
    else $error("start too short");
  // Main scenarios reached
  c_read_done: cover property (avs_read && !avs_waitrequest);
  c_tx_start: cover property ($fell(tx_out));
  c_rts_stop: cover property ($rose(rts_n_out));
endmodule
bind uaf_top uaf_monitor u_uaf_monitor (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .rx_in(rx_in), .tx_out(tx_out), .cts_n_in(cts_n_in),
  .rts_n_out(rts_n_out), .irq_out(irq_out));

// File: dv/uaf_remote.sv
`timescale 1ns/1ps
// Remote UART, 8N1, its clear-to-send fed from our request output
module uaf_remote (
  input logic core_clk,
  input logic tx_out,
  input logic rts_n_out,
  output logic rx_in
);
  int bt = 16; // Clocks per bit, matched to the device mode
  bit pe = 1'b0; // Even parity bit after the data when set
  logic [7:0] rq[$]; // Characters taken off the device line
  logic [7:0] v; // Shift buffer
  logic p; // Parity seen on the line
  // Line idles high
  initial rx_in = 1'b1;
  // Send one character, never starting while told to stop
  task automatic send(input logic [7:0] d);
    logic [10:0] f = pe ? {1'b1, ^d, d, 1'b0} : {2'b11, d, 1'b0};
    while (rts_n_out !== 1'b0) @(posedge core_clk);
    for (int i = 0; i < 10 + pe; i++) begin
      rx_in <= f[i];
      repeat (bt) @(posedge core_clk);
    end
  endtask
  // Receive: find the fall, sample each bit mid-way, drop bad stops
  initial forever begin
    @(negedge tx_out);
    repeat (bt / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bt) @(posedge core_clk);
      v[i] = tx_out;
    end
    p = ^v;
    if (pe) begin
      repeat (bt) @(posedge core_clk);
      p = tx_out;
    end
    repeat (bt) @(posedge core_clk);
    if (tx_out && p == ^v) rq.push_back(v);
  end
endmodule

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic core_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, cts_n_in = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic avs_waitrequest, rx_in, tx_out, rts_n_out, irq_out;
  int mismatches = 0, total_checks = 0, seed = 32'h33a0;
  logic [7:0] b, txq[$], rxq[$]; // Model queues of bytes in flight
  // 200 MHz clock
  always #2.5 core_clk = ~core_clk;
  uaf_top u_uaf_top (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_in(rx_in), .tx_out(tx_out), .cts_n_in(cts_n_in),
    .rts_n_out(rts_n_out), .irq_out(irq_out));
  uaf_remote u_uaf_remote (.core_clk(core_clk), .tx_out(tx_out), .rts_n_out(rts_n_out), .rx_in(rx_in));
  // Compare one byte
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // Verdict
  task automatic finish_test();
    if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One Avalon access held until waitrequest low, then one idle cycle
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] wd);
    avs_address <= a;
    avs_writedata <= {24'h0, wd};
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    b = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  // Read a register, compare the masked byte
  task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    cmp($sformatf("reg%0h", a), e, b & m);
  endtask
  // Write a random byte for transmission
  task automatic txb();
    b = 8'($random(seed));
    txq.push_back(b);
    bus(1'b1, 4'h0, b);
  endtask
  // Wait for the remote to hold every queued byte, compare in order
  task automatic txchk();
    while (u_uaf_remote.rq.size() < txq.size()) @(posedge core_clk);
    repeat (16) @(posedge core_clk);
    while (txq.size() > 0) cmp("tx", txq.pop_front(), u_uaf_remote.rq.pop_front());
  endtask
  // Remote sends n random bytes
  task automatic rxs(input int n);
    repeat (n) begin
      b = 8'($random(seed));
      rxq.push_back(b);
      u_uaf_remote.send(b);
    end
    repeat (4) @(posedge core_clk);
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    cmp("rts", 8'h01, {7'h0, rts_n_out});
    rchk(4'h3, 8'hff, 8'h03);
    rchk(4'h5, 8'h60, 8'h60);
    rchk(4'hf, 8'hff, 8'h00);
    bus(1'b1, 4'h4, 8'h02);
    repeat (3) @(posedge core_clk);
    cmp("rts", 8'h00, {7'h0, rts_n_out});
    // Single-byte mode: holding empties once the shifter loads
    txb();
    repeat (20) @(posedge core_clk);
    rchk(4'h5, 8'h60, 8'h20);
    bus(1'b1, 4'h1, 8'h02);
    repeat (2) @(posedge core_clk);
    cmp("irq", 8'h01, {7'h0, irq_out});
    bus(1'b1, 4'h1, 8'h00);
    repeat (2) @(posedge core_clk);
    cmp("irq", 8'h00, {7'h0, irq_out});
    txchk();
    rchk(4'h5, 8'h60, 8'h60);
    // FIFO mode in each sampling rate, both directions
    bus(1'b1, 4'h2, 8'h01);
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, 4'h7, 8'(m << 4));
      u_uaf_remote.bt = 16 >> m;
      repeat (4) txb();
      rchk(4'h5, 8'h20, 8'h00);
      txchk();
      rchk(4'h5, 8'h60, 8'h60);
      rxs(3);
      rchk(4'h5, 8'h01, 8'h01);
      while (rxq.size() > 0) rchk(4'h0, 8'hff, rxq.pop_front());
      rchk(4'h5, 8'h01, 8'h00);
    end
    // Eight bits with even parity, both directions
    bus(1'b1, 4'h3, 8'h1b);
    u_uaf_remote.pe = 1'b1;
    txb();
    txchk();
    rxs(1);
    rchk(4'h5, 8'h0c, 8'h00);
    rchk(4'h0, 8'hff, rxq.pop_front());
    bus(1'b1, 4'h3, 8'h03);
    u_uaf_remote.pe = 1'b0;
    // Stop request raised in mid character
    bus(1'b1, 4'h7, 8'h00);
    u_uaf_remote.bt = 16;
    bus(1'b1, 4'h6, 8'h90);
    bus(1'b1, 4'h1, 8'h80);
    txb();
    txb();
    repeat (30) @(posedge core_clk);
    cts_n_in <= 1'b1;
    repeat (400) @(posedge core_clk);
    cmp("sent", 8'h01, 8'(u_uaf_remote.rq.size()));
    cmp("irq", 8'h01, {7'h0, irq_out});
    rchk(4'h2, 8'h20, 8'h20);
    cts_n_in <= 1'b0;
    txchk();
    // Automatic request output with hysteresis, off at 16 entries, on again at 0
    bus(1'b1, 4'h6, 8'h50);
    bus(1'b1, 4'h1, 8'h40);
    rxs(16);
    cmp("rts", 8'h01, {7'h0, rts_n_out});
    rchk(4'h2, 8'h20, 8'h20);
    for (int i = 0; i < 16; i++) begin
      cmp("rts", 8'h01, {7'h0, rts_n_out});
      rchk(4'h0, 8'hff, rxq.pop_front());
    end
    repeat (3) @(posedge core_clk);
    cmp("rts", 8'h00, {7'h0, rts_n_out});
    finish_test();
  end
  // Hang guard, well past the expected run length
  initial begin
    repeat (30000) @(posedge core_clk);
    mismatches++;
    finish_test();
  end
endmodule
